// ### logic/gvs_bus_if.sv
// Shared memory, symbol ROM and slot signalling between graphics end and host end.
`timescale 1ns/1ps
interface gvs_bus_if;
  import gvs_pkg::*;

  logic [11:0] dev_addr;
  logic        dev_oe;
  logic [11:0] host_addr;
  logic        host_oe;
  logic [15:0] host_wdata;
  logic        host_we;
  logic [15:0] mem_rdata;
  logic [10:0] rom_addr;
  logic [7:0]  rom_data;
  logic        grant;
  gvs_slot_t   slot;
  logic [15:0] coll;
  logic        steal;
  logic [11:0] mem_addr;

  // Address seen by the shared memory: whichever end is driving.
  assign mem_addr = dev_oe ? dev_addr : host_addr;

  modport dev (output dev_addr, dev_oe, rom_addr, grant, slot, coll,
               input mem_rdata, rom_data, steal);
  modport host (output host_addr, host_oe, host_wdata, host_we, steal,
                input grant, slot, coll, mem_rdata);
endinterface

// ### logic/gvs_host_end.sv
// Host end: register port for software, shared memory access in host slots, interrupts.
`timescale 1ns/1ps
module gvs_host_end
  import gvs_pkg::*;
(
  gvs_bus_if.host     bus,
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic [31:0] reg_rdata,
  output logic        irq
);

  typedef struct packed {
    logic        steal;
    logic [2:0]  istat;
    logic [2:0]  imask;
    logic [11:0] maddr;
    logic [15:0] mwdata;
    logic [15:0] mrdata;
    logic [15:0] coll;
    logic        busy;
    logic        cmd_wr;
    logic        grant_q;
    gvs_slot_t   slot_q;
    logic [31:0] rdata;
    logic [11:0] host_addr;
    logic        host_oe;
    logic        host_we;
    logic        irq;
  } gvs_host_state_t;

  gvs_host_state_t hs_reg;
  gvs_host_state_t hs_next;

  // Next-state logic: register access, memory command and event capture.
  always_comb begin
    logic [2:0] ev;
    ev             = 3'h0;
    hs_next        = hs_reg;
    hs_next.rdata  = 32'h00000000;
    hs_next.host_oe = 1'b0;
    hs_next.host_we = 1'b0;
    hs_next.grant_q = bus.grant;
    hs_next.slot_q  = bus.slot;

    // Register reads answer one cycle later; unmapped offsets read zero.
    if (reg_re) begin
      unique case (reg_addr)
        REG_CTRL:   hs_next.rdata = {31'h0, hs_reg.steal};
        REG_STATUS: hs_next.rdata = {27'h0, hs_reg.busy, bus.grant, bus.slot};
        REG_ISTAT:  hs_next.rdata = {29'h0, hs_reg.istat};
        REG_IMASK:  hs_next.rdata = {29'h0, hs_reg.imask};
        REG_MADDR:  hs_next.rdata = {20'h0, hs_reg.maddr};
        REG_MWDATA: hs_next.rdata = {16'h0, hs_reg.mwdata};
        REG_MRDATA: hs_next.rdata = {16'h0, hs_reg.mrdata};
        REG_COLL:   hs_next.rdata = {16'h0, hs_reg.coll};
        default:    hs_next.rdata = 32'h00000000;
      endcase
    end

    // Register writes; address and data are locked while a command runs.
    if (reg_we) begin
      unique case (reg_addr)
        REG_CTRL:   hs_next.steal = reg_wdata[0]; // [RQ3] [RQ18]
        REG_ISTAT:  hs_next.istat = hs_reg.istat & ~reg_wdata[2:0];
        REG_IMASK:  hs_next.imask = reg_wdata[2:0];
        REG_MADDR:  if (!hs_reg.busy) hs_next.maddr = reg_wdata[11:0];
        REG_MWDATA: if (!hs_reg.busy) hs_next.mwdata = reg_wdata[15:0];
        REG_MCMD: begin
          if (!hs_reg.busy && (reg_wdata[0] || reg_wdata[1])) begin
            hs_next.busy   = 1'b1;
            hs_next.cmd_wr = reg_wdata[0];
          end
        end
        default: ;
      endcase
    end

    // Memory access: one driven cycle, started only while the graphics end grants the bus.
    if (hs_reg.host_oe) begin
      if (!hs_reg.cmd_wr) begin
        hs_next.mrdata = bus.mem_rdata;
      end
      hs_next.busy  = 1'b0;
      ev[IRQ_DONE]  = 1'b1;
    end else if (hs_reg.busy && bus.grant) begin // [RQ10] [RQ19] [RQ2]
      hs_next.host_oe   = 1'b1;
      hs_next.host_we   = hs_reg.cmd_wr;
      hs_next.host_addr = hs_reg.maddr;
    end

    // Events: host window opens, interaction flags become readable.
    ev[IRQ_WIN] = bus.grant && !hs_reg.grant_q;
    if (bus.slot == SL_POST && hs_reg.slot_q != SL_POST) begin
      ev[IRQ_COLL] = 1'b1;
      hs_next.coll = bus.coll; // [RQ9]
    end

    // A new event wins over a clear in the same cycle.
    hs_next.istat = hs_next.istat | ev;
    hs_next.irq   = |(hs_next.istat & hs_next.imask);
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_reg <= '0;
    end else begin
      hs_reg <= hs_next;
    end
  end

  assign bus.host_addr  = hs_reg.host_addr;
  assign bus.host_oe    = hs_reg.host_oe;
  assign bus.host_we    = hs_reg.host_we;
  assign bus.host_wdata = hs_reg.mwdata;
  assign bus.steal      = hs_reg.steal;
  assign reg_rdata      = hs_reg.rdata;
  assign irq            = hs_reg.irq;

endmodule

// ### logic/gvs_pkg.sv
// Shared constants and types for the game video frame sequencer and its host end.
// Operation
// (RQ1) Each 1/60 s frame has five memory slots.
// (RQ2) First slot gives host the shared memory.
// (RQ3) Host may steal whole frames, no picture.
// (RQ4) 192 active lines, 45 of 63.5 us.
// (RQ5) Line blanking processes next line's objects.
// (RQ6) Two pre lines fetch 40 descriptor bytes.
// (RQ7) Descriptors: eight objects, border, background, offsets.
// (RQ8) End of pre lines fetches object dots.
// (RQ9) Interactions held for host after picture.
// (RQ10) Host drives addresses only outside picture.
// (RQ11) Background reads from 000, 20 per line.
// (RQ12) Each card row reread for 16 lines.
// (RQ13) Background word: symbol address plus instruction.
// (RQ14) After each line fetch next object rows.
// (RQ15) Objects and cards merged, objects win.
// (RQ16) Record object/object and object/background coincidences.
// (RQ17) Non-interlaced output with sync and blanking.
// (RQ18) Uniform colour while host prepares game.
// (RQ19) Bus ownership changes at slot boundaries only.
package gvs_pkg;

  // Timing figures in their own units.
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned FRAME_HZ      = 60;
  localparam int unsigned LINE_NS       = 63500;
  localparam int unsigned ACT_NS        = 45000;
  localparam int unsigned HBL_NS        = 17800;
  localparam int unsigned HFP_NS        = 1500;
  localparam int unsigned HS_NS         = 4700;
  localparam int unsigned FRAME_LINES_I = 1000000000 / (FRAME_HZ * LINE_NS);
  localparam int unsigned HBL_CYC       = HBL_NS / CLK_NS;
  localparam int unsigned HFP_CYC       = HFP_NS / CLK_NS;
  localparam int unsigned HS_CYC        = HS_NS / CLK_NS;
  localparam int unsigned GUARD_CYC     = 2;

  // Line map of one frame: host lines, two pre lines, picture, two post lines.
  localparam logic [8:0] FRAME_LINES = 9'(FRAME_LINES_I);
  localparam logic [8:0] PRE_LINES   = 9'h002;
  localparam logic [8:0] ACT_LINES   = 9'h0c0;
  localparam logic [8:0] POST_LINES  = 9'h002;
  localparam logic [8:0] VS_LINES    = 9'h003;
  localparam logic [8:0] HOST_LINES  = FRAME_LINES - PRE_LINES - ACT_LINES - POST_LINES;
  localparam logic [8:0] FIRST_ACT   = HOST_LINES + PRE_LINES;
  localparam logic [8:0] LAST_ACT    = FIRST_ACT + ACT_LINES - 9'h001;
  localparam logic [8:0] FIRST_POST  = FIRST_ACT + ACT_LINES;

  // Picture geometry and fetch schedule within line blanking.
  localparam int unsigned DESC_WORDS  = 40;
  localparam int unsigned N_OBJ       = 8;
  localparam int unsigned CARDS       = 20;
  localparam int unsigned GROUP_LINES = 16;
  localparam int unsigned DOTS_LINE   = 160;
  localparam logic [12:0] FT_ROM      = 13'h0018;
  localparam logic [12:0] FT_OBJ      = 13'h0030;
  localparam logic [11:0] BG_BASE     = 12'h000;
  localparam logic [11:0] DESC_BASE   = 12'h100;

  // Descriptor byte positions and attribute bits.
  localparam int unsigned DESC_BORDER = 32;
  localparam int unsigned DESC_BGCOL  = 33;
  localparam int unsigned DESC_OFFX   = 34;
  localparam int unsigned DESC_OFFY   = 35;
  localparam int unsigned ATTR_VIS    = 0;
  localparam int unsigned ATTR_HFLIP  = 1;
  localparam int unsigned ATTR_VFLIP  = 2;
  localparam int unsigned ATTR_COL    = 3;

  // Host register offsets and interrupt bits.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ISTAT  = 8'h08;
  localparam logic [7:0] REG_IMASK  = 8'h0c;
  localparam logic [7:0] REG_MADDR  = 8'h10;
  localparam logic [7:0] REG_MWDATA = 8'h14;
  localparam logic [7:0] REG_MCMD   = 8'h18;
  localparam logic [7:0] REG_MRDATA = 8'h1c;
  localparam logic [7:0] REG_COLL   = 8'h20;
  localparam int unsigned IRQ_WIN   = 0;
  localparam int unsigned IRQ_COLL  = 1;
  localparam int unsigned IRQ_DONE  = 2;

  typedef enum logic [2:0] {
    SL_HOST = 3'h0,
    SL_PRE  = 3'h1,
    SL_ACT  = 3'h2,
    SL_HBL  = 3'h3,
    SL_POST = 3'h4
  } gvs_slot_t;

  typedef logic [DESC_WORDS-1:0][7:0] gvs_desc_t;

endpackage

// ### logic/gvs_video_end.sv
// Graphics end: frame sequencer, descriptor and card fetch, object merge and sync.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
module gvs_video_end
  import gvs_pkg::*;
#(
  parameter int unsigned LINE_CYC   = LINE_NS / CLK_NS,
  parameter int unsigned ACT_CYC    = ACT_NS / CLK_NS,
  parameter logic [3:0]  WASH_COLOR = 4'h1
) (
  gvs_bus_if.dev     bus,
  input  wire logic       clk,
  input  wire logic       rst_b,
  output logic [3:0] video_color,
  output logic       video_sync,
  output logic       video_blank
);

  localparam int unsigned DOT_CYC = ACT_CYC / DOTS_LINE;
  localparam logic [12:0] P_ACT   = 13'(ACT_CYC);
  localparam logic [12:0] P_LAST  = 13'(LINE_CYC - 1);
  localparam logic [12:0] P_GUARD = 13'(LINE_CYC - GUARD_CYC);
  // Sync position scales with the line length, so a shortened line still carries its pulse.
  localparam int unsigned FULL_CYC = LINE_NS / CLK_NS;
  localparam logic [12:0] P_HS0   = 13'(ACT_CYC + HFP_CYC * LINE_CYC / FULL_CYC);
  localparam logic [12:0] P_HS1   = 13'(ACT_CYC + (HFP_CYC + HS_CYC) * LINE_CYC / FULL_CYC);
  localparam logic [12:0] P_HBL   = 13'(HBL_CYC);
  localparam logic [4:0]  P_DOT   = 5'(DOT_CYC - 1);

  typedef struct packed {
    logic [12:0]                 pcnt;
    logic [8:0]                  line;
    logic [7:0]                  dot;
    logic [4:0]                  sub;
    logic                        steal;
    gvs_desc_t                   desc;
    logic [CARDS-1:0][7:0]       bg_card;
    logic [CARDS-1:0][3:0]       bg_attr;
    logic [CARDS-1:0][7:0]       bg_dots;
    logic [N_OBJ-1:0][7:0]       obj_row;
    logic [15:0]                 coll;
    logic [15:0]                 coll_q;
    logic [11:0]                 dev_addr;
    logic                        dev_oe;
    logic [10:0]                 rom_addr;
    logic                        grant;
    gvs_slot_t                   slot;
    logic [3:0]                  color;
    logic                        sync;
    logic                        blank;
  } gvs_dev_state_t;

  gvs_dev_state_t st_reg;
  gvs_dev_state_t st_next;

  // Shared memory address of background card k for picture line na.
  function automatic logic [11:0] card_addr(input logic [8:0] na, input logic [12:0] k);
    logic [11:0] grp;
    grp = 12'(na / 9'(GROUP_LINES));
    return BG_BASE + 12'(grp * 12'(CARDS)) + k[11:0];
  endfunction

  // Dot row of object i that lands on picture line na.
  function automatic logic [7:0] obj_rel(input gvs_desc_t d, input int i, input logic [8:0] na);
    return na[7:0] - d[4*i+1];
  endfunction

  // Reverse a dot row for mirrored objects.
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int b = 0; b < 8; b++) begin
      r[b] = v[7-b];
    end
    return r;
  endfunction

  // Next-state logic for the whole graphics end.
  always_comb begin
    logic [12:0]      h;
    logic [8:0]       na;
    logic [7:0]       r;
    logic [7:0]       dx;
    logic [7:0]       attr;
    logic [N_OBJ-1:0] hit;
    logic             bg_bit;
    logic             act_line;
    logic             in_pic;
    logic             own;
    logic             fetch_ok;
    logic [3:0]       pix;
    int               idx;
    h        = st_reg.pcnt - P_ACT;
    na       = st_reg.line - FIRST_ACT + 9'h001;
    r        = 8'h00;
    dx       = 8'h00;
    attr     = 8'h00;
    hit      = '0;
    bg_bit   = 1'b0;
    pix      = 4'h0;
    idx      = 0;
    st_next  = st_reg;
    act_line = (st_reg.line >= FIRST_ACT) && (st_reg.line <= LAST_ACT);
    in_pic   = act_line && (st_reg.pcnt < P_ACT) && !st_reg.steal;
    own      = !st_reg.steal && (st_reg.line >= HOST_LINES) && (st_reg.line <= LAST_ACT);
    fetch_ok = own && (st_reg.line >= FIRST_ACT - 9'h001) && (st_reg.line < LAST_ACT);

    // Line and frame counters; every frame is the same set of lines.
    if (st_reg.pcnt == P_LAST) begin // [RQ1] [RQ4] [RQ17]
      st_next.pcnt = 13'h0000;
      st_next.dot  = 8'h00;
      st_next.sub  = 5'h00;
      st_next.line = (st_reg.line == FRAME_LINES - 9'h001) ? 9'h000 : st_reg.line + 9'h001;
    end else begin
      st_next.pcnt = st_reg.pcnt + 13'h0001;
      if (in_pic && st_reg.dot < 8'(DOTS_LINE)) begin
        if (st_reg.sub == P_DOT) begin
          st_next.sub = 5'h00;
          st_next.dot = st_reg.dot + 8'h01;
        end else begin
          st_next.sub = st_reg.sub + 5'h01;
        end
      end
    end

    // The host's request to keep the memory is taken once, ahead of the pre lines.
    if (st_reg.line == HOST_LINES - 9'h001 && st_reg.pcnt == 13'h0000) begin
      st_next.steal = bus.steal; // [RQ3]
    end

    // Descriptor fetch during the first pre line's blanking.
    st_next.dev_addr = 12'h000;
    if (own && st_reg.line == HOST_LINES && st_reg.pcnt >= P_ACT) begin // [RQ6] [RQ7]
      if (h < 13'(DESC_WORDS)) begin
        st_next.dev_addr = DESC_BASE + h[11:0];
      end
      if (h >= 13'h0001 && h <= 13'(DESC_WORDS)) begin
        st_next.desc[h - 13'h0001] = bus.mem_rdata[7:0];
      end
    end

    // Card words, card dots and object rows for the next line.
    st_next.rom_addr = 11'h000;
    if (fetch_ok && st_reg.pcnt >= P_ACT && h < P_HBL) begin // [RQ5]
      if (h < 13'(CARDS)) begin
        st_next.dev_addr = card_addr(na, h); // [RQ11] [RQ12]
      end
      if (h >= 13'h0001 && h <= 13'(CARDS)) begin
        st_next.bg_card[h - 13'h0001] = bus.mem_rdata[7:0]; // [RQ13]
        st_next.bg_attr[h - 13'h0001] = bus.mem_rdata[11:8];
      end
      if (h >= FT_ROM && h < FT_ROM + 13'(CARDS)) begin
        st_next.rom_addr = {st_reg.bg_card[h - FT_ROM], na[3:1]}; // [RQ12]
      end
      if (h > FT_ROM && h <= FT_ROM + 13'(CARDS)) begin
        st_next.bg_dots[h - FT_ROM - 13'h0001] = bus.rom_data;
      end
      if (h >= FT_OBJ && h < FT_OBJ + 13'(N_OBJ)) begin // [RQ8] [RQ14]
        idx  = int'(h - FT_OBJ);
        r    = obj_rel(st_reg.desc, idx, na);
        attr = st_reg.desc[4*idx+3];
        st_next.rom_addr = {st_reg.desc[4*idx+2], attr[ATTR_VFLIP] ? ~r[2:0] : r[2:0]};
      end
      if (h > FT_OBJ && h <= FT_OBJ + 13'(N_OBJ)) begin
        idx  = int'(h - FT_OBJ) - 1;
        r    = obj_rel(st_reg.desc, idx, na);
        attr = st_reg.desc[4*idx+3];
        st_next.obj_row[idx] = 8'h00;
        if (attr[ATTR_VIS] && r < 8'h08) begin
          st_next.obj_row[idx] = attr[ATTR_HFLIP] ? rev8(bus.rom_data) : bus.rom_data;
        end
      end
    end

    // Flags start clear with the first picture line; a hit in that cycle still counts.
    if (st_reg.line == FIRST_ACT && st_reg.pcnt == 13'h0000) begin
      st_next.coll = 16'h0000;
    end

    // Dot merge: background first, objects over it, lowest object on top.
    if (in_pic && st_reg.dot < 8'(DOTS_LINE)) begin
      bg_bit = st_reg.bg_dots[st_reg.dot[7:3]][3'h7 - st_reg.dot[2:0]];
      pix    = bg_bit ? st_reg.bg_attr[st_reg.dot[7:3]] : st_reg.desc[DESC_BGCOL][3:0];
      if (st_reg.dot < st_reg.desc[DESC_OFFX]) begin
        pix = st_reg.desc[DESC_BORDER][3:0];
      end
      for (int i = 0; i < N_OBJ; i++) begin
        dx     = st_reg.dot - st_reg.desc[4*i];
        hit[i] = (dx < 8'h08) && st_reg.obj_row[i][3'h7 - dx[2:0]];
      end
      for (int i = N_OBJ - 1; i >= 0; i--) begin
        if (hit[i]) begin
          attr = st_reg.desc[4*i+3];
          pix  = attr[ATTR_COL+3:ATTR_COL]; // [RQ15]
        end
      end
      for (int i = 0; i < N_OBJ; i++) begin
        if (hit[i] && ((hit & ~(N_OBJ'(1) << i)) != '0)) begin
          st_next.coll[i] = 1'b1; // [RQ16]
        end
        if (hit[i] && bg_bit) begin
          st_next.coll[N_OBJ + i] = 1'b1; // [RQ16]
        end
      end
    end

    // Interaction flags are frozen for the host as the post lines begin.
    if (st_reg.line == FIRST_POST && st_reg.pcnt == 13'h0000) begin
      st_next.coll_q = st_reg.coll; // [RQ9]
    end

    // Video outputs; a stolen frame shows one flat colour.
    st_next.blank = !(act_line && st_reg.pcnt < P_ACT); // [RQ17]
    st_next.color = (st_reg.steal && !st_next.blank) ? WASH_COLOR :
                    (in_pic ? pix : 4'h0); // [RQ18]
    st_next.sync  = ((st_reg.pcnt >= P_HS0) && (st_reg.pcnt < P_HS1)) ^
                    (st_reg.line < VS_LINES); // [RQ17]

    // Slot and ownership; the host loses its grant just before the pre lines.
    if (st_reg.steal || st_reg.line < HOST_LINES) begin
      st_next.slot = SL_HOST; // [RQ2]
    end else if (st_reg.line < FIRST_ACT) begin
      st_next.slot = SL_PRE;
    end else if (st_reg.line <= LAST_ACT) begin
      st_next.slot = (st_reg.pcnt < P_ACT) ? SL_ACT : SL_HBL;
    end else begin
      st_next.slot = SL_POST;
    end
    st_next.dev_oe = own; // [RQ19]
    st_next.grant  = !own && !(st_reg.line == HOST_LINES - 9'h001 &&
                               st_reg.pcnt >= P_GUARD && !st_reg.steal); // [RQ19] [RQ10]
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.dev_addr  = st_reg.dev_addr;
  assign bus.dev_oe    = st_reg.dev_oe;
  assign bus.rom_addr  = st_reg.rom_addr;
  assign bus.grant     = st_reg.grant;
  assign bus.slot      = st_reg.slot;
  assign bus.coll      = st_reg.coll_q;
  assign video_color   = st_reg.color;
  assign video_sync    = st_reg.sync;
  assign video_blank   = st_reg.blank;

endmodule

// ### testbench/game_video_frame_sequencer_tb.sv
// Self-checking bench joining the graphics end and the host end over the shared bus.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module game_video_frame_sequencer_tb;
  import gvs_pkg::*;
  localparam int unsigned LINE_C = 380;
  localparam int unsigned ACT_C  = 320;
  logic        clk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [31:0] reg_rdata;
  logic        irq;
  logic [3:0]  video_color;
  logic        video_sync;
  logic        video_blank;
  logic [31:0] rdv;
  logic [15:0] mem [0:4095];
  logic [7:0]  rom [0:2047];
  gvs_slot_t   prev_slot;
  int          num_errors;
  int          checks;
  int          act_lines;
  int          act_cyc;

  gvs_bus_if bus ();
  gvs_video_end #(.LINE_CYC(LINE_C), .ACT_CYC(ACT_C)) gvs_video_end_inst (.bus(bus),
    .clk(clk), .rst_b(rst_b), .video_color(video_color), .video_sync(video_sync),
    .video_blank(video_blank));
  gvs_host_end gvs_host_end_inst (.bus(bus), .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq));
  gvs_frame_checker gvs_frame_checker_inst (.clk(clk), .rst_b(rst_b), .dev_addr(bus.dev_addr),
    .dev_oe(bus.dev_oe), .host_oe(bus.host_oe), .host_we(bus.host_we), .grant(bus.grant),
    .slot(bus.slot), .coll(bus.coll));

  // Shared RAM and symbol ROM answer at once; host writes land on the clock edge.
  assign bus.mem_rdata = mem[bus.mem_addr];
  assign bus.rom_data = rom[bus.rom_addr];
  always @(posedge clk) begin
    if (bus.host_oe && bus.host_we) mem[bus.host_addr] <= bus.host_wdata;
  end

  // Counts picture lines and picture cycles of the first frame.
  always @(posedge clk) begin
    if (bus.slot === SL_ACT) act_cyc++;
    if (bus.slot === SL_ACT && prev_slot !== SL_ACT) act_lines++;
    prev_slot <= bus.slot;
  end

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Issues a memory command and polls the busy bit under a bound.
  task automatic mem_cmd(input logic [31:0] cmd);
    int n;
    wr(REG_MCMD, cmd);
    n = 0;
    rdv = 32'h10;
    while (rdv[4] !== 1'b0 && n < 100) begin
      rd(REG_STATUS, rdv);
      n++;
    end
    `CHK(rdv[4], 1'b0)
  endtask

  task automatic wait_slot(input gvs_slot_t s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (bus.slot !== s && n < 120000);
    `CHK(bus.slot, s)
  endtask

  task automatic test_done();
    $display("counts: %0d checks, %0d mismatches", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cuts a hang short just after the first frame and its post lines should have passed.
  initial begin
    #1000000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    num_errors = 0;
    checks = 0;
    act_lines = 0;
    act_cyc = 0;
    // Solid background cards, and two visible objects stacked on one spot.
    for (int i = 0; i < 4096; i++) mem[i] = (i < 240) ? 16'h0001 : 16'h0000;
    for (int i = 0; i < 2048; i++) rom[i] = (i / 8 == 1 || i / 8 == 2) ? 8'hff : 8'h00;
    for (int k = 0; k < 2; k++) begin
      mem[256 + 4 * k] = 16'h000a;
      mem[257 + 4 * k] = 16'h000a;
      mem[258 + 4 * k] = 16'h0002;
      mem[259 + 4 * k] = 16'h0011 + 16'(8 * k);
    end
    repeat (2) @(posedge clk);
    `CHK(bus.grant, 1'b0)
    `CHK(bus.dev_oe, 1'b0)
    `CHK(irq, 1'b0)
    rst_b <= 1'b1;
    wr(REG_IMASK, 32'h4);
    rd(REG_IMASK, rdv);
    `CHK(rdv, 32'h4)
    rd(8'hfc, rdv);
    `CHK(rdv, 32'h0)
    rd(REG_STATUS, rdv);
    `CHK(rdv, 32'h8)
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL, rdv);
    `CHK(rdv, 32'h1)
    wr(REG_CTRL, 32'h0);
    rd(REG_CTRL, rdv);
    `CHK(rdv, 32'h0)
    `CHK(video_sync, 1'b1)
    $display("test registers done");
    wr(REG_MADDR, 32'h200);
    wr(REG_MWDATA, 32'hbeef);
    mem_cmd(32'h1);
    `CHK(mem[12'h200], 16'hbeef)
    mem_cmd(32'h2);
    rd(REG_MRDATA, rdv);
    `CHK(rdv, 32'hbeef)
    `CHK(irq, 1'b1)
    rd(REG_ISTAT, rdv);
    `CHK(rdv, 32'h5)
    wr(REG_ISTAT, 32'h5);
    rd(REG_ISTAT, rdv);
    `CHK(rdv, 32'h0)
    `CHK(irq, 1'b0)
    wr(REG_IMASK, 32'h2);
    $display("test host slot done");
    wait_slot(SL_PRE);
    `CHK(bus.grant, 1'b0)
    wait_slot(SL_ACT);
    `CHK(video_blank, 1'b0)
    `CHK(video_sync, 1'b0)
    repeat (10) begin
      wait_slot(SL_HBL);
      wait_slot(SL_ACT);
    end
    repeat (23) @(posedge clk);
    #1 `CHK(video_color, 4'h2)
    wait_slot(SL_HBL);
    repeat (3) @(posedge clk);
    #1 `CHK(video_blank, 1'b1)
    repeat (10) @(posedge clk);
    #1 `CHK(video_sync, 1'b1)
    $display("test picture done");
    wait_slot(SL_POST);
    rd(REG_COLL, rdv);
    `CHK(rdv, 32'h0303)
    `CHK(bus.coll, 16'h0303)
    `CHK(act_lines, 192)
    `CHK(act_cyc, 192 * ACT_C)
    `CHK(bus.grant, 1'b1)
    rd(REG_ISTAT, rdv);
    `CHK(rdv[1], 1'b1)
    `CHK(irq, 1'b1)
    wr(REG_MADDR, 32'h10);
    mem_cmd(32'h2);
    rd(REG_MRDATA, rdv);
    `CHK(rdv, 32'h1)
    $display("test post slot done");
    test_done();
  end
endmodule

// ### testbench/gvs_frame_checker.sv
// Concurrent checks on the shared bus between the graphics end and the host end.
`timescale 1ns/1ps
module gvs_frame_checker
  import gvs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [11:0] dev_addr,
  input wire logic        dev_oe,
  input wire logic        host_oe,
  input wire logic        host_we,
  input wire logic        grant,
  input wire gvs_slot_t   slot,
  input wire logic [15:0] coll
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Bus ownership and the host access window.
  chk_no_overlap: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the memory address");
  chk_host_granted: assert property (host_oe |-> $past(grant))
    else $error("host drove the bus without grant in the cycle before");
  chk_host_pulse: assert property (host_oe |=> !host_oe)
    else $error("host access longer than one cycle");
  chk_write_strobe: assert property (host_we |-> host_oe)
    else $error("write strobe without address drive");
  chk_picture_locked: assert property ((slot inside {SL_PRE, SL_ACT, SL_HBL}) |-> !grant)
    else $error("grant high while picture slots run");
  chk_post_grant: assert property (slot == SL_POST |-> grant)
    else $error("host not granted after the picture");

  // Graphics fetch order, address ranges, bus take and release, frozen interaction flags.
  chk_desc_step: assert property ((dev_oe && dev_addr == DESC_BASE) |=>
    dev_addr == DESC_BASE + 12'h001) else $error("descriptor walk did not step");
  chk_card_range: assert property (dev_oe |-> (dev_addr < 12'h0f0 ||
    (dev_addr >= DESC_BASE && dev_addr < DESC_BASE + 12'h028)))
    else $error("graphics address out of range");
  chk_rise_pre: assert property ($rose(dev_oe) |-> ##[0:2] slot == SL_PRE)
    else $error("graphics end took bus outside pre lines");
  chk_fall_post: assert property ($fell(dev_oe) |-> ##[0:2] slot == SL_POST)
    else $error("graphics end released bus outside post lines");
  chk_coll_frozen: assert property ($changed(coll) |-> !dev_oe)
    else $error("interaction flags changed during picture");

  cover property (host_we);
  cover property ($rose(dev_oe));
  cover property (slot == SL_POST);
  cover property (coll != 16'h0000);
endmodule
